// >>> pkg/port_pkg.sv
package port_pkg;
    localparam logic [11:0] ADDR_DATA = 12'h008;
    localparam logic [11:0] ADDR_DIR = 12'h00C;
    localparam logic [11:0] ADDR_PULLUP = 12'h010;
    localparam logic [11:0] ADDR_SERIAL_CTRL = 12'h014;
    localparam logic [11:0] ADDR_FIRST_DIR = 12'h018;
    localparam int FIRST_WIDTH = 8;
    localparam int SECOND_WIDTH = 2;
    localparam int PIN_UPPER = 1;
    localparam int PIN_LOWER = 0;
    localparam logic [7:0] PULLUP_RESET = 8'h00;
    localparam logic [1:0] DIR_RESET = 2'h0;
    localparam logic [1:0] LATCH_RESET = 2'h0;
    localparam logic [7:0] FIRST_DIR_RESET = 8'h00;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_FILL = 32'h0000_0000;
    localparam logic RX_IDLE = 1'b1;
endpackage : port_pkg

// >>> core/port_pullup_and_serial_pin_port.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ns
module port_pullup_and_serial_pin_port
    import port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] first_port_pullup_on,
    input wire logic [1:0] second_pin_in,
    output logic [1:0] second_pin_out,
    output logic [1:0] second_pin_oe_n,
    input wire logic serial_tx_data,
    input wire logic serial_tx_drive,
    output logic serial_rx_data
);
    logic [7:0] pullup_reg, pullup_next;
    logic [7:0] first_dir_reg, first_dir_next;
    logic [1:0] latch_reg, latch_next;
    logic [1:0] dir_reg, dir_next;
    logic enable_reg, enable_next;
    logic [1:0] sync1_reg, sync2_reg;
    logic [31:0] prdata_reg, prdata_next;
    logic wr_en, rd_en, rd_setup, mapped;

    // Decoding shared by mapped check and read mux
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        return a == r;
    endfunction : hit

    // Per-pin read source; the same pick is checked by the assertions below
    function automatic logic [1:0] port_read(input logic [1:0] dir, input logic [1:0] latch,
        input logic [1:0] pin);
        return (dir & latch) | (~dir & pin);
    endfunction : port_read

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    // Read data fetched in the setup cycle so prdata comes from a flop
    assign rd_setup = psel & ~penable & ~pwrite;
    assign mapped = hit(paddr, ADDR_DATA) | hit(paddr, ADDR_DIR) | hit(paddr, ADDR_PULLUP)
        | hit(paddr, ADDR_SERIAL_CTRL) | hit(paddr, ADDR_FIRST_DIR);
    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Two-flop sync of the pin levels before any read path
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync1_reg <= SYNC_RESET;
            sync2_reg <= SYNC_RESET;
        end else begin
            sync1_reg <= second_pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Register writes and read data
    always_comb begin
        pullup_next = pullup_reg;
        first_dir_next = first_dir_reg;
        latch_next = latch_reg;
        dir_next = dir_reg;
        enable_next = enable_reg;
        prdata_next = prdata_reg;
        if (wr_en) begin
            if (hit(paddr, ADDR_PULLUP)) begin
                pullup_next = pwdata[7:0];
            end
            if (hit(paddr, ADDR_FIRST_DIR)) begin
                first_dir_next = pwdata[7:0];
            end
            if (hit(paddr, ADDR_DATA)) begin
                latch_next = pwdata[1:0];
            end
            if (hit(paddr, ADDR_DIR)) begin
                dir_next = pwdata[1:0];
            end
            if (hit(paddr, ADDR_SERIAL_CTRL)) begin
                enable_next = pwdata[0];
            end
        end
        if (rd_setup) begin
            prdata_next = READ_FILL;
            if (hit(paddr, ADDR_DATA)) begin
                // Direction picks source even under serial ownership
                prdata_next[1:0] = port_read(dir_reg, latch_reg, sync2_reg);
            end
            if (hit(paddr, ADDR_DIR)) begin
                prdata_next[1:0] = dir_reg;
            end
            if (hit(paddr, ADDR_PULLUP)) begin
                prdata_next[7:0] = pullup_reg;
            end
            if (hit(paddr, ADDR_SERIAL_CTRL)) begin
                prdata_next[0] = enable_reg;
            end
            if (hit(paddr, ADDR_FIRST_DIR)) begin
                prdata_next[7:0] = first_dir_reg;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pullup_reg <= PULLUP_RESET;
            first_dir_reg <= FIRST_DIR_RESET;
            latch_reg <= LATCH_RESET;
            dir_reg <= DIR_RESET;
            enable_reg <= ENABLE_RESET;
            prdata_reg <= RDATA_RESET;
        end else begin
            pullup_reg <= pullup_next;
            first_dir_reg <= first_dir_next;
            latch_reg <= latch_next;
            dir_reg <= dir_next;
            enable_reg <= enable_next;
            prdata_reg <= prdata_next;
        end
    end

    // Read data straight from the flop; loaded at setup, so still no wait state
    assign prdata = prdata_reg;

    // Pullups only on input pins; 1 connects the pullup
    generate
        for (genvar i = 0; i < FIRST_WIDTH; i++) begin : g_pullup
            assign first_port_pullup_on[i] = pullup_reg[i] & ~first_dir_reg[i];
        end
    endgenerate

    // Pin ownership: serial unit overrides direction while enabled
    always_comb begin
        second_pin_out = latch_reg;
        second_pin_oe_n = ~dir_reg;
        if (enable_reg) begin
            second_pin_oe_n[PIN_UPPER] = 1'b1;
            second_pin_out[PIN_LOWER] = serial_tx_data;
            second_pin_oe_n[PIN_LOWER] = ~serial_tx_drive;
        end
    end
    assign serial_rx_data = enable_reg ? sync2_reg[PIN_UPPER] : RX_IDLE;

    // Reset leaves both second-port pins as inputs
    AST_DIR_RESET: assert property (@(posedge clk_sys)
        $fell(reset) |-> dir_reg == DIR_RESET)
        else $error("direction not cleared by reset");

    // Buffers off right after reset, before any write
    AST_OE_RESET: assert property (@(posedge clk_sys)
        $fell(reset) |-> second_pin_oe_n == ~DIR_RESET)
        else $error("pins driven after reset");

    // An output pin never keeps its pullup
    AST_PULLUP_OUT: assert property (@(posedge clk_sys) disable iff (reset)
        first_dir_reg[0] |-> !first_port_pullup_on[0])
        else $error("pullup on output pin");

    // Enabled pullup on an input pin is connected
    AST_PULLUP_ON: assert property (@(posedge clk_sys) disable iff (reset)
        pullup_reg[3] && !first_dir_reg[3] |-> first_port_pullup_on[3])
        else $error("pullup missing");

    // A zero bit keeps the pullup disconnected whatever the direction
    AST_PULLUP_OFF: assert property (@(posedge clk_sys) disable iff (reset)
        !pullup_reg[5] |-> !first_port_pullup_on[5])
        else $error("pullup connected while disabled");

    // Pullup bits take the written byte
    AST_PULLUP_WR: assert property (@(posedge clk_sys) disable iff (reset)
        wr_en && hit(paddr, ADDR_PULLUP) |=> pullup_reg == $past(pwdata[7:0]))
        else $error("pullup enables not written");

    // Direction writes leave the pullup enables alone
    AST_PULLUP_ALONE: assert property (@(posedge clk_sys) disable iff (reset)
        wr_en && hit(paddr, ADDR_FIRST_DIR) |=> pullup_reg == $past(pullup_reg))
        else $error("pullup enables disturbed");

    // Each first-port pin gated on its own bits only
    generate
        for (genvar k = 0; k < FIRST_WIDTH; k++) begin : g_pullup_chk
            AST_PULLUP_BIT: assert property (@(posedge clk_sys) disable iff (reset)
                first_port_pullup_on[k] == (pullup_reg[k] && !first_dir_reg[k]))
                else $error("pullup bit not independent");
        end
    endgenerate

    // Latch written whatever the direction
    AST_LATCH_WR: assert property (@(posedge clk_sys) disable iff (reset)
        wr_en && hit(paddr, ADDR_DATA) |=> latch_reg == $past(pwdata[1:0]))
        else $error("latch not written");

    // Latch only moves on a data write
    AST_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
        !(wr_en && hit(paddr, ADDR_DATA)) |=> latch_reg == $past(latch_reg))
        else $error("latch changed without write");

    // In general-purpose use the latch feeds the pins
    AST_LATCH_OUT: assert property (@(posedge clk_sys) disable iff (reset)
        !enable_reg |-> second_pin_out == latch_reg)
        else $error("latch not on pins");

    // Direction takes the two written bits
    AST_DIR_WR: assert property (@(posedge clk_sys) disable iff (reset)
        wr_en && hit(paddr, ADDR_DIR) |=> dir_reg == $past(pwdata[1:0]))
        else $error("direction not written");

    // A set direction bit turns the buffer on
    AST_DIR_DRIVE: assert property (@(posedge clk_sys) disable iff (reset)
        !enable_reg && dir_reg[PIN_UPPER] |-> !second_pin_oe_n[PIN_UPPER])
        else $error("output buffer off");

    // A clear direction bit leaves the pin floating as input
    AST_DIR_FLOAT: assert property (@(posedge clk_sys) disable iff (reset)
        !enable_reg && !dir_reg[PIN_LOWER] |-> second_pin_oe_n[PIN_LOWER])
        else $error("input pin driven");

    // Read value was picked in the setup cycle, one edge earlier
    AST_READ_SEL: assert property (@(posedge clk_sys) disable iff (reset)
        rd_en && hit(paddr, ADDR_DATA) |->
        prdata[1:0] == $past(port_read(dir_reg, latch_reg, sync2_reg)))
        else $error("data read source wrong");

    // Unused direction bits read zero
    AST_UPPER_ZERO: assert property (@(posedge clk_sys) disable iff (reset)
        rd_en && hit(paddr, ADDR_DIR) |-> prdata[31:2] == 30'h0)
        else $error("upper bits nonzero");

    // Unused data bits read zero
    AST_DATA_ZERO: assert property (@(posedge clk_sys) disable iff (reset)
        rd_en && hit(paddr, ADDR_DATA) |-> prdata[31:2] == 30'h0)
        else $error("upper data bits nonzero");

    // Serial unit owns the upper pin as an input
    AST_RX_OWN: assert property (@(posedge clk_sys) disable iff (reset)
        enable_reg |-> second_pin_oe_n[PIN_UPPER] && serial_rx_data == sync2_reg[PIN_UPPER])
        else $error("receive pin not owned");

    // Receiver sees an idle line while the unit is off
    AST_RX_IDLE: assert property (@(posedge clk_sys) disable iff (reset)
        !enable_reg |-> serial_rx_data == RX_IDLE)
        else $error("receive line not idle");

    // Serial unit data reaches the lower pin
    AST_TX_OWN: assert property (@(posedge clk_sys) disable iff (reset)
        enable_reg |-> second_pin_out[PIN_LOWER] == serial_tx_data)
        else $error("transmit pin not owned");

    // Serial unit, not direction, decides lower pin drive
    AST_TX_DRIVE: assert property (@(posedge clk_sys) disable iff (reset)
        enable_reg |-> second_pin_oe_n[PIN_LOWER] == !serial_tx_drive)
        else $error("transmit drive not from serial unit");

    // With the unit off, direction rules the buffers again
    AST_GPIO_BACK: assert property (@(posedge clk_sys) disable iff (reset)
        !enable_reg |-> second_pin_oe_n == ~dir_reg)
        else $error("pins not general purpose");

    // Serial enable bit takes the written value
    AST_SERIAL_WR: assert property (@(posedge clk_sys) disable iff (reset)
        wr_en && hit(paddr, ADDR_SERIAL_CTRL) |=> enable_reg == $past(pwdata[0]))
        else $error("serial enable not written");

    // Zero wait states on every access
    AST_NO_WAIT: assert property (@(posedge clk_sys) disable iff (reset)
        psel && penable |-> pready)
        else $error("access stalled");

    // Refused writes change nothing
    AST_REFUSED: assert property (@(posedge clk_sys) disable iff (reset)
        pslverr && pwrite |=> latch_reg == $past(latch_reg) && dir_reg == $past(dir_reg)
        && pullup_reg == $past(pullup_reg))
        else $error("refused write landed");

    // Refused reads return the fill value
    AST_ERR_ZERO: assert property (@(posedge clk_sys) disable iff (reset)
        pslverr && !pwrite |-> prdata == READ_FILL)
        else $error("refused read not zero");

    // Pin levels reach logic only through both flops
    AST_SYNC_PIPE: assert property (@(posedge clk_sys) disable iff (reset)
        sync2_reg == $past(sync1_reg))
        else $error("synchroniser skipped");

    // Main scenarios
    COV_WRITE_LATCH: cover property (@(posedge clk_sys) wr_en && hit(paddr, ADDR_DATA));
    COV_READ_PIN: cover property (@(posedge clk_sys) rd_en && hit(paddr, ADDR_DATA) && !dir_reg[0]);
    COV_SERIAL_ON: cover property (@(posedge clk_sys) $rose(enable_reg));
    COV_SERIAL_OFF: cover property (@(posedge clk_sys) $fell(enable_reg));
    COV_REFUSED: cover property (@(posedge clk_sys) pslverr);
endmodule : port_pullup_and_serial_pin_port

// >>> testbench/board_serial_model.sv
`timescale 1ns/1ns
module board_serial_model (
    input wire logic [1:0] second_pin_out,
    input wire logic [1:0] second_pin_oe_n,
    input wire logic [1:0] board_level,
    input wire logic tx_bit,
    input wire logic tx_en,
    output logic [1:0] second_pin_in,
    output logic serial_tx_data,
    output logic serial_tx_drive
);
    // Device wins where it drives, board level elsewhere
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            second_pin_in[i] = second_pin_oe_n[i] ? board_level[i] : second_pin_out[i];
        end
    end
    // Serial line idles high between characters
    assign serial_tx_data = tx_en ? tx_bit : 1'b1;
    assign serial_tx_drive = tx_en;
endmodule : board_serial_model

// >>> testbench/port_pullup_and_serial_pin_port_test.sv
`timescale 1ns/1ns
module port_pullup_and_serial_pin_port_test;
    import port_pkg::*;
    logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, tx_bit, tx_en, e;
    logic serial_tx_data, serial_tx_drive, serial_rx_data;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] first_port_pullup_on;
    logic [1:0] second_pin_in, second_pin_out, second_pin_oe_n, board_level;
    int bad_count = 0;
    int n_tests = 0;
    port_pullup_and_serial_pin_port dut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .first_port_pullup_on(first_port_pullup_on),
        .second_pin_in(second_pin_in), .second_pin_out(second_pin_out),
        .second_pin_oe_n(second_pin_oe_n), .serial_tx_data(serial_tx_data),
        .serial_tx_drive(serial_tx_drive), .serial_rx_data(serial_rx_data));
    board_serial_model partner (.second_pin_out(second_pin_out),
        .second_pin_oe_n(second_pin_oe_n), .board_level(board_level), .tx_bit(tx_bit),
        .tx_en(tx_en), .second_pin_in(second_pin_in), .serial_tx_data(serial_tx_data),
        .serial_tx_drive(serial_tx_drive));
    // 50 MHz system clock
    initial begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Response taken at the access edge, before the design's flops move
    always @(posedge clk_sys) begin
        if (psel && penable && pready) begin
            q <= prdata;
            e <= pslverr;
        end
    end
    // One APB transfer; waits on pready, the watchdog cuts a hang
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        psel <= 0; penable <= 0;
        // Let the captured response settle before the caller looks
        @(negedge clk_sys);
    endtask : apb
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", nm, x, g);
        end
    endtask : chk
    task close_out;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    // Watchdog, generous against some 60 cycles of tests
    initial begin
        repeat (3000) @(posedge clk_sys);
        bad_count++;
        close_out;
    end
    initial begin
        reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        board_level = 2'h1; tx_bit = 1; tx_en = 0;
        repeat (6) @(posedge clk_sys);
        reset <= 0;
        apb(0, ADDR_DIR, 0); chk("dir", 0, q);
        chk("resp ok", 0, 32'(e));
        chk("oe_n", 32'(2'h3), 32'(second_pin_oe_n));
        apb(1, ADDR_PULLUP, 32'hA5); apb(0, ADDR_PULLUP, 0); chk("pue", 32'hA5, q);
        chk("pullup", 32'hA5, 32'(first_port_pullup_on));
        apb(1, ADDR_FIRST_DIR, 32'h0F);
        chk("pullup gated", 32'hA0, 32'(first_port_pullup_on));
        // Latch loaded before direction turns on, so no glitch
        apb(1, ADDR_DATA, 32'hFF); apb(0, ADDR_DATA, 0); chk("pin read", 1, q);
        apb(1, ADDR_DIR, 32'hFF);
        apb(0, ADDR_DIR, 0); chk("dir bits", 3, q);
        apb(0, ADDR_DATA, 0); chk("latch read", 3, q);
        chk("out", 32'(2'h3), 32'(second_pin_out));
        chk("oe on", 0, 32'(second_pin_oe_n));
        board_level <= 2'h0; tx_en <= 1;
        apb(1, ADDR_SERIAL_CTRL, 1); apb(0, ADDR_DATA, 0); chk("owned read", 3, q);
        chk("serial oe", 32'(2'h2), 32'(second_pin_oe_n));
        chk("tx out", 1, 32'(second_pin_out[PIN_LOWER]));
        chk("rx", 0, 32'(serial_rx_data));
        apb(1, ADDR_DIR, 0); apb(0, ADDR_DATA, 0); chk("owned pins", 1, q);
        apb(1, ADDR_SERIAL_CTRL, 0); repeat (3) @(posedge clk_sys);
        chk("released oe", 32'(2'h3), 32'(second_pin_oe_n));
        chk("rx idle", 1, 32'(serial_rx_data));
        apb(1, 12'hFFC, 32'hFF); chk("refused err", 1, 32'(e));
        apb(0, ADDR_DIR, 0); chk("dir kept", 0, q);
        apb(0, 12'hFFC, 0); chk("unmapped err", 1, 32'(e));
        chk("unmapped data", 0, q);
        close_out;
    end
endmodule : port_pullup_and_serial_pin_port_test
